/* File: src/sco_consts.vh */
// constants for the sensor command output block
`ifndef SCO_CONSTS_VH
`define SCO_CONSTS_VH
`define SCO_OFS_SEL     8'h00
`define SCO_OFS_COMP    8'h04
`define SCO_OFS_SERIAL  8'h08
`define SCO_OFS_STATUS  8'h0c
`define SCO_OFS_FLD0    8'h20
`define SCO_OFS_FLD8    8'h40
`define SCO_AK_NONE     3'h0
`define SCO_AK_SEL      3'h1
`define SCO_AK_COMP     3'h2
`define SCO_AK_SERIAL   3'h3
`define SCO_AK_STATUS   3'h4
`define SCO_AK_FLD      3'h5
`define SCO_RST_SEL     16'h0006
`define SCO_RST_COMP    16'h2000
`define SCO_RST_SERIAL  16'h0000
`define SCO_CH_CR       8'h0d
`define SCO_CH_LF       8'h0a
`define SCO_CH_SP       8'h20
`define SCO_CH_ZERO     8'h30
`define SCO_CH_NINE     8'h39
`define SCO_CMD_RDCOMP  8'h73
`define SCO_CMD_WRCOMP  8'h53
`define SCO_CMD_SEL     8'h4d
`define SCO_CMD_POLL    8'h51
`define SCO_CMD_ID      8'h59
`define SCO_NFIELDS     9
`define SCO_MAX_FIELDS  3'h5
`define SCO_MAX_DIGITS  3'h5
`define SCO_LAST_DIGIT  3'h4
`define SCO_CONV_STEPS  5'h10
`define SCO_ID_LEN      41
`define SCO_ID_LAST     6'h28
`define SCO_BIT_DSM     4'hb
`define SCO_BIT_DRAW    4'ha
`define SCO_BIT_ZSP     4'h8
`define SCO_BIT_TRAW    4'h7
`define SCO_BIT_LSM     4'h5
`define SCO_BIT_LRAW    4'h4
`define SCO_BIT_TSM     4'h3
`define SCO_BIT_GFLT    4'h2
`define SCO_BIT_GRAW    4'h1
`define SCO_TAG_DSM     8'h64
`define SCO_TAG_DRAW    8'h44
`define SCO_TAG_ZSP     8'h68
`define SCO_TAG_TRAW    8'h56
`define SCO_TAG_LED     8'h30
`define SCO_TAG_TSM     8'h76
`define SCO_TAG_GFLT    8'h5a
`define SCO_TAG_GRAW    8'h7a
`endif

/* File: src/sco_dec_acc.v */
// decimal digit accumulator for command arguments
`timescale 1ns/1ns
`include "sco_consts.vh"
module sco_dec_acc (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clear,
    input  wire        dig_valid,
    input  wire [3:0]  dig,
    output reg  [15:0] value,
    output reg  [2:0]  count
);
    wire [15:0] next_value;

    // wraps modulo 65536; digits past the fifth are dropped
    assign next_value = value * 16'h000a + {12'h000, dig};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= 16'h0000;
            count <= 3'h0;
        end else if (clear) begin
            value <= 16'h0000;
            count <= 3'h0;
        end else if (dig_valid && count < `SCO_MAX_DIGITS) begin
            value <= next_value;
            count <= count + 3'h1;
        end
    end
endmodule // sco_dec_acc

/* File: src/sco_bin2dec.v */
// binary to five bcd digits, shift and add-three
`timescale 1ns/1ns
`include "sco_consts.vh"
module sco_bin2dec (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        start,
    input  wire [15:0] bin,
    output reg         done,
    output reg  [19:0] digits
);
    reg  [15:0] shreg;
    reg  [4:0]  cnt;
    reg         busy;
    wire [19:0] adj;

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_adj
            assign adj[4*g+:4] = (digits[4*g+:4] > 4'h4) ?
                                 digits[4*g+:4] + 4'h3 : digits[4*g+:4];
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg  <= 16'h0000;
            cnt    <= 5'h00;
            busy   <= 1'b0;
            done   <= 1'b0;
            digits <= 20'h0_0000;
        end else begin
            done <= 1'b0;
            if (start) begin
                shreg  <= bin;
                digits <= 20'h0_0000;
                cnt    <= `SCO_CONV_STEPS;
                busy   <= 1'b1;
            end else if (busy) begin
                digits <= {adj[18:0], shreg[15]};
                shreg  <= {shreg[14:0], 1'b0};
                cnt    <= cnt - 5'h01;
                if (cnt == 5'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // sco_bin2dec

/* File: src/sco_top.v */
// sensor ascii command interpreter with apb register access
//
// Contract
// RULE_01 - "s" CR LF answers "s", space, compensation as five digits, CR LF.
// RULE_02 - one output line carries at most five measurement fields.
// RULE_03 - each field is tag character, one space, five-digit decimal value.
// RULE_04 - weights 2048, 1024, 256 select fields tagged d, D, h.
// RULE_05 - weights 128 and 8 select temperature fields tagged V and v.
// RULE_06 - weights 32 and 16 select led signal fields, both tagged 0.
// RULE_07 - weights 4 and 2 select gas fields tagged Z and z.
// RULE_08 - host forms the selector as the sum of wanted weights.
// RULE_09 - selector resets to 6, giving both gas concentration fields.
// RULE_10 - host should enable at most two fields at once.
// RULE_11 - "M n" stores selector, echoes "M" and five-digit value, CR LF.
// RULE_12 - "Q" returns latest values of exactly the enabled fields; the code sends only the first five when more are enabled.
// RULE_13 - "Y" returns two lines, each ended by CR LF.
// RULE_14 - line one: Y, date, time, revision; line two: B id number.
// RULE_15 - host stops measurement before asking for identification.
// RULE_16 - "S n" sets compensation, default 8192, echoed as five digits.
// RULE_17 - fields go out in descending weight, space separated, then CR LF.
`timescale 1ns/1ns
`include "sco_consts.vh"
module sco_top #(
    // identification text, arbitrary neutral values
    parameter [8*`SCO_ID_LEN-1:0] ID_TEXT =
        "Y,Jan 01 2000,00:00:00,REV0001\015\012B 000001 "
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  rx_data,
    input  wire        rx_valid,
    output reg         rx_ready,
    output reg  [7:0]  tx_data,
    output reg         tx_valid,
    input  wire        tx_ready
);
    localparam P_CMD  = 2'h0;
    localparam P_ARG  = 2'h1;
    localparam P_LF   = 2'h2;

    localparam R_IDLE = 4'h0;
    localparam R_STR  = 4'h1;
    localparam R_TAG  = 4'h2;
    localparam R_SP   = 4'h3;
    localparam R_CONV = 4'h4;
    localparam R_DIG  = 4'h5;
    localparam R_SEP  = 4'h6;
    localparam R_CR   = 4'h7;
    localparam R_LF   = 4'h8;

    reg  [15:0] sel;
    reg  [15:0] comp;
    reg  [15:0] serial;
    reg  [15:0] fval [0:`SCO_NFIELDS-1];
    reg  [1:0]  ps;
    reg  [7:0]  cmd;
    reg         bad;
    reg         go;
    reg  [3:0]  rs;
    reg  [7:0]  kind;
    reg  [3:0]  fcur;
    reg  [2:0]  fcount;
    reg  [5:0]  sidx;
    reg  [2:0]  didx;
    reg         conv_start;
    reg  [15:0] conv_val;
    reg  [7:0]  tag;
    reg  [4:0]  nf;
    wire        rx_fire;
    wire        is_digit;
    wire        known;
    wire        slot;
    wire        resp_end;
    wire [15:0] acc_value;
    wire [2:0]  acc_count;
    wire        conv_done;
    wire [19:0] conv_digits;
    wire [2:0]  ak;
    wire [7:0]  foff;
    wire [3:0]  aidx;
    wire [5:0]  sidx_rev;
    wire [3:0]  dig_nib;
    integer     k;

    // RULE_04 weight to bit map
    // RULE_05 temperature weights
    // RULE_06 led signal weights
    // RULE_07 gas weights
    function [3:0] field_bit;
        input [3:0] idx;
        begin
            case (idx)
                4'h0:    field_bit = `SCO_BIT_DSM;
                4'h1:    field_bit = `SCO_BIT_DRAW;
                4'h2:    field_bit = `SCO_BIT_ZSP;
                4'h3:    field_bit = `SCO_BIT_TRAW;
                4'h4:    field_bit = `SCO_BIT_LSM;
                4'h5:    field_bit = `SCO_BIT_LRAW;
                4'h6:    field_bit = `SCO_BIT_TSM;
                4'h7:    field_bit = `SCO_BIT_GFLT;
                default: field_bit = `SCO_BIT_GRAW;
            endcase
        end
    endfunction

    // RULE_04 field tag characters
    function [7:0] field_tag;
        input [3:0] idx;
        begin
            case (idx)
                4'h0:    field_tag = `SCO_TAG_DSM;
                4'h1:    field_tag = `SCO_TAG_DRAW;
                4'h2:    field_tag = `SCO_TAG_ZSP;
                4'h3:    field_tag = `SCO_TAG_TRAW;
                4'h4:    field_tag = `SCO_TAG_LED;
                4'h5:    field_tag = `SCO_TAG_LED;
                4'h6:    field_tag = `SCO_TAG_TSM;
                4'h7:    field_tag = `SCO_TAG_GFLT;
                default: field_tag = `SCO_TAG_GRAW;
            endcase
        end
    endfunction

    // RULE_17 descending weight search
    function [4:0] next_field;
        input [15:0] m;
        input [3:0]  from;
        integer      i;
        reg          found;
        begin
            next_field = 5'h00;
            found = 1'b0;
            for (i = 0; i < `SCO_NFIELDS; i = i + 1) begin
                if (!found && i >= from && m[field_bit(i[3:0])]) begin
                    found = 1'b1;
                    next_field = {1'b1, i[3:0]};
                end
            end
        end
    endfunction

    function [2:0] addr_kind;
        input [7:0] a;
        begin
            if (a[1:0] != 2'b00)
                addr_kind = `SCO_AK_NONE;
            else if (a == `SCO_OFS_SEL)
                addr_kind = `SCO_AK_SEL;
            else if (a == `SCO_OFS_COMP)
                addr_kind = `SCO_AK_COMP;
            else if (a == `SCO_OFS_SERIAL)
                addr_kind = `SCO_AK_SERIAL;
            else if (a == `SCO_OFS_STATUS)
                addr_kind = `SCO_AK_STATUS;
            else if (a >= `SCO_OFS_FLD0 && a <= `SCO_OFS_FLD8)
                addr_kind = `SCO_AK_FLD;
            else
                addr_kind = `SCO_AK_NONE;
        end
    endfunction

    assign ak       = addr_kind(paddr);
    assign foff     = paddr - `SCO_OFS_FLD0;
    assign aidx     = foff[5:2];
    assign rx_fire  = rx_valid & rx_ready;
    assign is_digit = (rx_data >= `SCO_CH_ZERO) && (rx_data <= `SCO_CH_NINE);
    assign known    = (cmd == `SCO_CMD_RDCOMP) || (cmd == `SCO_CMD_WRCOMP) ||
                      (cmd == `SCO_CMD_SEL) || (cmd == `SCO_CMD_POLL) ||
                      (cmd == `SCO_CMD_ID);
    assign slot     = ~tx_valid | tx_ready;
    assign resp_end = (rs == R_LF) & slot;
    assign sidx_rev = `SCO_ID_LAST - sidx;
    assign dig_nib  = conv_digits[{`SCO_LAST_DIGIT - didx, 2'b00}+:4];

    sco_dec_acc u_acc (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (rx_fire && ps == P_CMD),
        .dig_valid (rx_fire && ps == P_ARG && is_digit),
        .dig       (rx_data[3:0]),
        .value     (acc_value),
        .count     (acc_count)
    );

    sco_bin2dec u_conv (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (conv_start),
        .bin     (conv_val),
        .done    (conv_done),
        .digits  (conv_digits)
    );

    // apb slave: zero wait, read data latched in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b1;
            pslverr <= 1'b0;
            // RULE_09 selector default six
            sel     <= `SCO_RST_SEL;
            comp    <= `SCO_RST_COMP;
            serial  <= `SCO_RST_SERIAL;
            for (k = 0; k < `SCO_NFIELDS; k = k + 1)
                fval[k] <= 16'h0000;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= (ak == `SCO_AK_NONE);
                if (ak == `SCO_AK_SEL)
                    prdata <= {16'h0000, sel};
                else if (ak == `SCO_AK_COMP)
                    prdata <= {16'h0000, comp};
                else if (ak == `SCO_AK_SERIAL)
                    prdata <= {16'h0000, serial};
                else if (ak == `SCO_AK_STATUS)
                    prdata <= {16'h0000, cmd, 7'h00, (rs != R_IDLE)};
                else if (ak == `SCO_AK_FLD)
                    prdata <= {16'h0000, fval[aidx]};
                else
                    prdata <= 32'h0000_0000;
            end
            if (psel && penable && pwrite) begin
                if (ak == `SCO_AK_SEL)
                    sel <= pwdata[15:0];
                else if (ak == `SCO_AK_COMP)
                    comp <= pwdata[15:0];
                else if (ak == `SCO_AK_SERIAL)
                    serial <= pwdata[15:0];
                else if (ak == `SCO_AK_FLD)
                    fval[aidx] <= pwdata[15:0];
            end
            // a link command wins over a same-cycle bus write
            // RULE_11 store selector
            if (go && cmd == `SCO_CMD_SEL && acc_count != 3'h0)
                sel <= acc_value;
            // RULE_16 store compensation
            if (go && cmd == `SCO_CMD_WRCOMP && acc_count != 3'h0)
                comp <= acc_value;
        end
    end

    // command parser; rx stalls while an answer is being sent
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps       <= P_CMD;
            cmd      <= 8'h00;
            bad      <= 1'b0;
            go       <= 1'b0;
            rx_ready <= 1'b1;
        end else begin
            go <= 1'b0;
            if (resp_end)
                rx_ready <= 1'b1;
            if (rx_fire) begin
                case (ps)
                    P_CMD: begin
                        // stray line ends between commands are skipped
                        if (rx_data != `SCO_CH_CR &&
                            rx_data != `SCO_CH_LF) begin
                            cmd <= rx_data;
                            bad <= 1'b0;
                            ps  <= P_ARG;
                        end
                    end
                    P_ARG: begin
                        if (rx_data == `SCO_CH_CR)
                            ps <= P_LF;
                        else if (!is_digit && rx_data != `SCO_CH_SP)
                            bad <= 1'b1;
                    end
                    default: begin
                        ps <= P_CMD;
                        if (rx_data == `SCO_CH_LF && !bad && known) begin
                            go       <= 1'b1;
                            rx_ready <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    always @* begin
        if (kind == `SCO_CMD_SEL)
            conv_val = sel;
        else if (kind == `SCO_CMD_ID)
            conv_val = serial;
        else if (kind == `SCO_CMD_POLL)
            conv_val = fval[fcur];
        else
            conv_val = comp;
        tag = (kind == `SCO_CMD_POLL) ? field_tag(fcur) : kind;
        nf  = next_field(sel, (rs == R_IDLE) ? 4'h0 : fcur + 4'h1);
    end

    // answer sequencer, one byte per free transmit slot
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rs         <= R_IDLE;
            kind       <= 8'h00;
            fcur       <= 4'h0;
            fcount     <= 3'h0;
            sidx       <= 6'h00;
            didx       <= 3'h0;
            conv_start <= 1'b0;
            tx_data    <= 8'h00;
            tx_valid   <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            if (tx_valid && tx_ready)
                tx_valid <= 1'b0;
            case (rs)
                R_IDLE: begin
                    if (go) begin
                        kind <= cmd;
                        sidx <= 6'h00;
                        // RULE_12 first enabled field
                        if (cmd == `SCO_CMD_ID)
                            rs <= R_STR;
                        else if (cmd != `SCO_CMD_POLL)
                            rs <= R_TAG;
                        else if (nf[4]) begin
                            fcur   <= nf[3:0];
                            fcount <= 3'h1;
                            rs     <= R_TAG;
                        end else
                            rs <= R_CR;
                    end
                end
                R_STR: if (slot) begin
                    // RULE_13 two-line identity
                    // RULE_14 id text then number
                    tx_data  <= ID_TEXT[{sidx_rev, 3'b000}+:8];
                    tx_valid <= 1'b1;
                    if (sidx == `SCO_ID_LAST) begin
                        rs         <= R_CONV;
                        conv_start <= 1'b1;
                    end else
                        sidx <= sidx + 6'h01;
                end
                R_TAG: if (slot) begin
                    // RULE_01 echo tag then value
                    // RULE_03 tag, space, digits
                    tx_data  <= tag;
                    tx_valid <= 1'b1;
                    rs       <= R_SP;
                end
                R_SP: if (slot) begin
                    tx_data    <= `SCO_CH_SP;
                    tx_valid   <= 1'b1;
                    rs         <= R_CONV;
                    conv_start <= 1'b1;
                end
                R_CONV: begin
                    didx <= 3'h0;
                    if (conv_done)
                        rs <= R_DIG;
                end
                R_DIG: if (slot) begin
                    tx_data  <= `SCO_CH_ZERO + {4'h0, dig_nib};
                    tx_valid <= 1'b1;
                    didx     <= didx + 3'h1;
                    if (didx == `SCO_LAST_DIGIT) begin
                        // RULE_02 five fields at most
                        // RULE_17 next lower weight
                        if (kind == `SCO_CMD_POLL && nf[4] &&
                            fcount < `SCO_MAX_FIELDS) begin
                            fcur   <= nf[3:0];
                            fcount <= fcount + 3'h1;
                            rs     <= R_SEP;
                        end else
                            rs <= R_CR;
                    end
                end
                R_SEP: if (slot) begin
                    tx_data  <= `SCO_CH_SP;
                    tx_valid <= 1'b1;
                    rs       <= R_TAG;
                end
                R_CR: if (slot) begin
                    tx_data  <= `SCO_CH_CR;
                    tx_valid <= 1'b1;
                    rs       <= R_LF;
                end
                R_LF: if (slot) begin
                    tx_data  <= `SCO_CH_LF;
                    tx_valid <= 1'b1;
                    rs       <= R_IDLE;
                end
                default: rs <= R_IDLE;
            endcase
        end
    end
endmodule // sco_top

/* File: bench/sco_chk.sv */
// assertion checker for the sensor command interpreter
`timescale 1ns/1ns
module sco_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_valid,
    input wire logic        rx_ready,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rx_hs = rx_valid && rx_ready;
    // a bare command byte, then its line end
    sequence s_cmd(c);
        rx_hs && rx_data == c ##1 rx_hs && rx_data == 8'h0d
            ##1 rx_hs && rx_data == 8'h0a;
    endsequence
    AST_RD_ECHO: assert property (
        s_cmd(8'h73) |-> ##[1:3] tx_valid && tx_data == 8'h73)
        else $error("read command not echoed");
    AST_ID_ECHO: assert property (
        s_cmd(8'h59) |-> ##[1:3] tx_valid && tx_data == 8'h59)
        else $error("id answer does not start with Y");
    AST_POLL_BUSY: assert property (
        s_cmd(8'h51) |=> !rx_ready [*2])
        else $error("poll answer did not hold off input");
    AST_TX_HOLD: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("answer byte dropped before accept");
    AST_TX_CHARS: assert property (
        tx_valid |-> tx_data inside {[8'h20:8'h7e], 8'h0d, 8'h0a})
        else $error("answer byte not printable");
    AST_LF_END: assert property (
        $rose(rx_ready) |-> tx_valid && tx_data == 8'h0a)
        else $error("answer did not end with line feed");
    AST_CR_LF: assert property (
        tx_valid && tx_ready && tx_data == 8'h0d
        |-> ##[1:4] tx_valid && tx_data == 8'h0a)
        else $error("carriage return without line feed");
    AST_RX_BACK: assert property (
        $fell(rx_ready) |-> ##[1:1000] rx_ready)
        else $error("input held off too long");
    AST_PREADY: assert property (
        psel && penable |-> pready)
        else $error("bus access not answered");
    AST_UNALIGN: assert property (
        psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("unaligned access not flagged");
endmodule // sco_chk

bind sco_top sco_chk u_sco_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready)
);

/* File: bench/sco_host.sv */
// host model: sends command lines, collects answer bytes
`timescale 1ns/1ns
module sco_host (
    input  wire logic       pclk,
    input  wire logic       slow,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            tx_ready
);
    logic [7:0] got[$];
    logic [1:0] cnt = 2'b00;
    // set when a byte is never taken within the bound
    logic       stuck = 1'b0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end
    // slow mode stalls the answer three cycles in four
    always @(posedge pclk) begin
        cnt <= cnt + 2'b01;
        tx_ready <= !slow || cnt == 2'b11;
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    end
    // no measurement runs here, so id is always allowed
    // each line is closed by CR LF by the caller
    task send(input string s);
        integer i;
        integer n;
        for (i = 0; i < s.len(); i++) begin
            rx_data <= s[i];
            rx_valid <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (rx_ready !== 1'b1 && n < 5000);
            if (n >= 5000)
                stuck = 1'b1;
        end
        rx_valid <= 1'b0;
        // released line must not keep the last byte
        rx_data <= ~s[s.len()-1];
    endtask
endmodule // sco_host

/* File: bench/tb_top.sv */
// testbench: register and command-line checks of the interpreter
`timescale 1ns/1ns
module tb_top;
    localparam [8*41-1:0] ID_V =
        "Y,Feb 02 2001,01:02:03,REV0002\015\012B 000777 ";
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        slow = 1'b0;
    logic [31:0] rd;
    logic        er;
    wire  [31:0] prdata;
    wire  [7:0]  rx_data;
    wire  [7:0]  tx_data;
    wire         pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready;
    integer      error_cnt = 0;
    integer      comparisons = 0;
    integer      i;
    int          w[9] = '{2048, 1024, 256, 128, 32, 16, 8, 4, 2};
    string       tg = "dDhV00vZz";
    always #20 pclk = ~pclk;
    sco_top #(.ID_TEXT(ID_V)) u_sco_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    sco_host u_sco_host (
        .pclk(pclk), .slow(slow), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_ready(tx_ready));
    task finish_test;
        $display("TB: %0d comparisons, %0d errors", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            finish_test;
        end
        @(posedge pclk);
    endtask
    task cmd(input string c, input string x);
        integer n;
        integer k;
        u_sco_host.got.delete();
        u_sco_host.send(c);
        n = 0;
        while ((u_sco_host.got.size() < x.len() || rx_ready !== 1'b1)
               && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 5000 || u_sco_host.stuck) begin
            error_cnt++;
            finish_test;
        end
        chk("answer length", u_sco_host.got.size(), x.len());
        for (k = 0; k < x.len(); k++)
            chk("answer byte", u_sco_host.got[k], x[k]);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("selector", rd, 32'h0000_0006);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk("compensation", rd, 32'h0000_2000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped error", er, 32'h0000_0001);
        chk("unmapped data", rd, 32'h0000_0000);
        apb(1'b0, 8'h05, 32'h0000_0000);
        chk("unaligned error", er, 32'h0000_0001);
        $display("TB: test reset_values done");
        slow <= 1'b1;
        cmd("s\r\n", "s 08192\r\n");
        slow <= 1'b0;
        cmd("S 123\r\n", "S 00123\r\n");
        cmd("S 9x\r\n", "");
        cmd("s\r\n", "s 00123\r\n");
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk("compensation", rd, 32'h0000_007b);
        $display("TB: test compensation done");
        for (i = 0; i < 9; i++)
            apb(1'b1, 8'(8'h20 + 4 * i), 32'(1000 + i));
        cmd("Q\r\n", "Z 01007 z 01008\r\n");
        // selector is the sum of wanted weights
        for (i = 0; i < 9; i++) begin
            cmd($sformatf("M %0d\r\n", w[i]),
                $sformatf("M %05d\r\n", w[i]));
            cmd("Q\r\n", $sformatf("%c %05d\r\n", tg[i],
                1000 + i));
        end
        // deliberately exceeds the advised two fields
        cmd("M 3504\r\n", "M 03504\r\n");
        cmd("Q\r\n", {"d 01000 D 01001 h 01002 V 01003 0 01004",
            "\r\n"});
        cmd("M 0\r\n", "M 00000\r\n");
        cmd("Q\r\n", "\r\n");
        $display("TB: test fields done");
        apb(1'b1, 8'h08, 32'h0000_002a);
        cmd("Y\r\n", $sformatf("%s00042\r\n", ID_V));
        apb(1'b0, 8'h0c, 32'h0000_0000);
        chk("status", rd, 32'h0000_5900);
        $display("TB: test identification done");
        finish_test;
    end
endmodule // tb_top
